//--- logic/timer_one_params.svh
/*
 offsets, field positions, reset values and response codes of the timer control block.
 assumes it is included by its bare name wherever these constants are needed.
 */
// Behaviour
// - polarity bit 7 clear counts while gate low, set counts while gate high.
// - gate enable ignored when stopped; when running and set, gate qualifies counting.
// - prescale bits 5:4: 11 divides by eight, 10 by four, 01 by two.
// - external source: sync bypass set skips resynchronising, clear resynchronises first; here set still reads the two-flop synchroniser, clear adds one stage.
// - internal source ignores sync bypass and counts the instruction clock.
// - run enable starts the timer when set, stops it holding its count when clear.
// - oscillator enable bit turns on the low-power crystal oscillator.
// - prescale counter is hidden; any write to either count byte clears it.
// - gate comes from gate pin or comparator output, chosen outside control register.
`ifndef TIMER_ONE_PARAMS_SVH
`define TIMER_ONE_PARAMS_SVH

// ****************************************
// register map
// ****************************************
`define ADDR_W            12
`define CTRL_OFFSET       12'h000
`define COUNT_OFFSET      12'h004
`define GATE_SRC_OFFSET   12'h008
`define CTRL_RESET        8'h00
`define COUNT_RESET       16'h0000

// ****************************************
// control field positions
// ****************************************
`define POLARITY_BIT      7
`define GATE_EN_BIT       6
`define PRESCALE_HI_BIT   5
`define PRESCALE_LO_BIT   4
`define OSC_EN_BIT        3
`define SYNC_BYPASS_BIT   2
`define CLK_SRC_BIT       1
`define RUN_BIT           0

// ****************************************
// bus responses
// ****************************************
`define RESP_OKAY         2'h0
`define RESP_SLVERR       2'h2

`endif

//--- logic/timer_one_pkg.sv
/*
 types of the timer control block.
 assumes the constants header sits beside it.
 */
package timer_one_pkg;
	typedef struct packed {
		logic       gate_polarity_select;
		logic       gate_enable;
		logic [1:0] prescale_select;
		logic       low_power_osc_enable;
		logic       sync_bypass;
		logic       clock_source_select;
		logic       timer_run_enable;
	} timer_one_control_t;

	typedef struct packed {
		logic [11:0] addr;
		logic        valid;
	} addr_hold_t;
endpackage

//--- logic/sixteen_bit_timer_control.sv
/*
 16-bit timer with its control register, reached over an axi4-lite slave.
 assumes external clock, gate pin and comparator output are asynchronous to aclk.
 */
// Implementation choices: the AXI4-Lite register port and the register addresses.
`timescale 1ns/1ps
`include "timer_one_params.svh"

module sixteen_bit_timer_control (
	// clock and reset
	input  wire logic        aclk,
	input  wire logic        aresetn,
	// write address channel
	input  wire logic [11:0] s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	// write data channel
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	// write response channel
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	// read address channel
	input  wire logic [11:0] s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	// read data channel
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	// timer pins
	input  wire logic        external_count_clock_pin,
	input  wire logic        gate_input_pin,
	input  wire logic        comparator_out,
	// timer state
	output logic             low_power_osc_enable,
	output logic [15:0]      count_value
);

	// ****************************************
	// state
	// ****************************************
	timer_one_pkg::timer_one_control_t ctrl;
	timer_one_pkg::timer_one_control_t next_ctrl;
	timer_one_pkg::addr_hold_t         aw_hold;
	timer_one_pkg::addr_hold_t         next_aw_hold;
	logic [31:0] w_data;
	logic [31:0] next_w_data;
	logic [3:0]  w_strb;
	logic [3:0]  next_w_strb;
	logic        w_have;
	logic        next_w_have;
	logic        gate_source_select;
	logic        next_gate_source_select;
	logic [15:0] count;
	logic [15:0] next_count;
	logic [2:0]  prescale_count;
	logic [2:0]  next_prescale_count;
	logic [2:0]  ext_sync;
	logic [1:0]  gate_sync;
	logic [1:0]  comp_sync;
	logic        ext_prev;
	logic        next_ext_prev;
	logic        bvalid;
	logic        next_bvalid;
	logic [1:0]  bresp;
	logic [1:0]  next_bresp;
	logic        rvalid;
	logic        next_rvalid;
	logic [31:0] rdata;
	logic [31:0] next_rdata;
	logic [1:0]  rresp;
	logic [1:0]  next_rresp;

	// ****************************************
	// combinational helpers
	// ****************************************
	logic       do_write;
	logic       ext_level;
	logic       source_edge;
	logic       gate_level;
	logic       gate_active;
	logic       count_enable;
	logic [2:0] prescale_mask;

	assign s_axi_awready        = !aw_hold.valid && !bvalid;
	assign s_axi_wready         = !w_have && !bvalid;
	assign s_axi_arready        = !rvalid;
	assign s_axi_bvalid         = bvalid;
	assign s_axi_bresp          = bresp;
	assign s_axi_rvalid         = rvalid;
	assign s_axi_rdata          = rdata;
	assign s_axi_rresp          = rresp;
	assign low_power_osc_enable = ctrl.low_power_osc_enable;
	assign count_value          = count;
	assign do_write             = aw_hold.valid && w_have && !bvalid;

	always_comb begin
		// bypass reads the two-flop output, synchronous mode adds one aligning stage
		ext_level = ctrl.sync_bypass ? ext_sync[1] : ext_sync[2];
		// internal source counts every instruction clock, bypass ignored
		source_edge = ctrl.clock_source_select ? (ext_level && !ext_prev) : 1'b1;
		gate_level = gate_source_select ? comp_sync[1] : gate_sync[1];
		gate_active = ctrl.gate_polarity_select ? gate_level : !gate_level;
		// gate only matters while running
		count_enable = ctrl.timer_run_enable && (!ctrl.gate_enable || gate_active);
		case (ctrl.prescale_select)
			2'h3: prescale_mask = 3'h7;
			2'h2: prescale_mask = 3'h3;
			2'h1: prescale_mask = 3'h1;
			default: prescale_mask = 3'h0;
		endcase
	end

	// ****************************************
	// next state
	// ****************************************
	always_comb begin
		next_ctrl               = ctrl;
		next_aw_hold            = aw_hold;
		next_w_data             = w_data;
		next_w_strb             = w_strb;
		next_w_have             = w_have;
		next_gate_source_select = gate_source_select;
		next_count              = count;
		next_prescale_count     = prescale_count;
		next_ext_prev           = ext_level;
		next_bvalid             = bvalid;
		next_bresp              = bresp;
		next_rvalid             = rvalid;
		next_rdata              = rdata;
		next_rresp              = rresp;

		// counting; a stopped timer holds its count
		if (count_enable && source_edge) begin
			if (prescale_count >= prescale_mask) begin
				next_prescale_count = 3'h0;
				next_count          = count + 16'h0001;
			end else begin
				next_prescale_count = prescale_count + 3'h1;
			end
		end

		// write channels
		if (s_axi_awvalid && s_axi_awready) begin
			next_aw_hold.addr  = s_axi_awaddr;
			next_aw_hold.valid = 1'b1;
		end
		if (s_axi_wvalid && s_axi_wready) begin
			next_w_data = s_axi_wdata;
			next_w_strb = s_axi_wstrb;
			next_w_have = 1'b1;
		end
		if (do_write) begin
			next_aw_hold.valid = 1'b0;
			next_w_have        = 1'b0;
			next_bvalid        = 1'b1;
			next_bresp         = `RESP_OKAY;
			if (aw_hold.addr[11:2] == 10'(`CTRL_OFFSET >> 2)) begin
				if (w_strb[0]) begin
					next_ctrl = w_data[7:0];
				end
			end else if (aw_hold.addr[11:2] == 10'(`COUNT_OFFSET >> 2)) begin
				if (w_strb[0]) begin
					next_count[7:0] = w_data[7:0];
				end
				if (w_strb[1]) begin
					next_count[15:8] = w_data[15:8];
				end
				// written count bytes win over an increment, an unwritten byte keeps the incremented value; either byte clears the prescaler
				if (w_strb[0] || w_strb[1]) begin
					next_prescale_count = 3'h0;
				end
			end else if (aw_hold.addr[11:2] == 10'(`GATE_SRC_OFFSET >> 2)) begin
				if (w_strb[0]) begin
					next_gate_source_select = w_data[0];
				end
			end else begin
				next_bresp = `RESP_SLVERR;
			end
		end
		if (bvalid && s_axi_bready) begin
			next_bvalid = 1'b0;
		end

		// read channels
		if (s_axi_arvalid && s_axi_arready) begin
			next_rvalid = 1'b1;
			next_rresp  = `RESP_OKAY;
			next_rdata  = 32'h0000_0000;
			if (s_axi_araddr[11:2] == 10'(`CTRL_OFFSET >> 2)) begin
				next_rdata[7:0] = ctrl;
			end else if (s_axi_araddr[11:2] == 10'(`COUNT_OFFSET >> 2)) begin
				next_rdata[15:0] = count;
			end else if (s_axi_araddr[11:2] == 10'(`GATE_SRC_OFFSET >> 2)) begin
				next_rdata[0] = gate_source_select;
			end else begin
				next_rresp = `RESP_SLVERR;
			end
		end else if (rvalid && s_axi_rready) begin
			next_rvalid = 1'b0;
		end
	end

	// ****************************************
	// registers
	// ****************************************
	always_ff @(posedge aclk) begin
		ext_sync  <= {ext_sync[1:0], external_count_clock_pin};
		gate_sync <= {gate_sync[0], gate_input_pin};
		comp_sync <= {comp_sync[0], comparator_out};
		if (!aresetn) begin
			ctrl               <= `CTRL_RESET;
			aw_hold            <= '0;
			w_data             <= 32'h0000_0000;
			w_strb             <= 4'h0;
			w_have             <= 1'b0;
			gate_source_select <= 1'b0;
			count              <= `COUNT_RESET;
			prescale_count     <= 3'h0;
			ext_prev           <= 1'b0;
			bvalid             <= 1'b0;
			bresp              <= `RESP_OKAY;
			rvalid             <= 1'b0;
			rdata              <= 32'h0000_0000;
			rresp              <= `RESP_OKAY;
		end else begin
			ctrl               <= next_ctrl;
			aw_hold            <= next_aw_hold;
			w_data             <= next_w_data;
			w_strb             <= next_w_strb;
			w_have             <= next_w_have;
			gate_source_select <= next_gate_source_select;
			count              <= next_count;
			prescale_count     <= next_prescale_count;
			ext_prev           <= next_ext_prev;
			bvalid             <= next_bvalid;
			bresp              <= next_bresp;
			rvalid             <= next_rvalid;
			rdata              <= next_rdata;
			rresp              <= next_rresp;
		end
	end

endmodule

//--- verification/timer_ctrl_properties.sv
/*
 bus handshake and count checks on the timer control top ports.
 assumes one clock, aclk, and a synchronous active-low reset.
 */
`timescale 1ns/1ps
module timer_ctrl_properties (
	// clock and reset
	input wire logic        aclk,
	input wire logic        aresetn,
	// bus handshakes
	input wire logic        s_axi_awready,
	input wire logic        s_axi_wready,
	input wire logic        s_axi_bvalid,
	input wire logic        s_axi_bready,
	input wire logic        s_axi_arvalid,
	input wire logic        s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic        s_axi_rvalid,
	input wire logic        s_axi_rready,
	// timer state
	input wire logic        low_power_osc_enable,
	input wire logic [15:0] count_value
);
	// ***
	// properties
	// ***
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	chk_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read answer late");
	chk_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data dropped");
	chk_ar_blocked: assert property (s_axi_rvalid |-> !s_axi_arready)
		else $error("read taken while busy");
	chk_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
		else $error("write answer dropped");
	chk_write_blocked: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
		else $error("write taken while busy");
	chk_bresp_release: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
		else $error("write answer stuck");
	chk_count_step: assert property (!$rose(s_axi_bvalid) |-> count_value == $past(count_value)
		|| count_value == $past(count_value) + 16'h1) else $error("count jumped");
	chk_osc_follow: assert property ($changed(low_power_osc_enable) |-> $rose(s_axi_bvalid))
		else $error("oscillator enable moved alone");
	cover property (s_axi_rvalid && !s_axi_rready);
	cover property ($rose(low_power_osc_enable));
	cover property ($fell(count_value[15]));
endmodule

bind sixteen_bit_timer_control timer_ctrl_properties i_timer_ctrl_properties (.aclk, .aresetn,
	.s_axi_awready, .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready,
	.s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .low_power_osc_enable, .count_value);

//--- verification/pin_source_model.sv
/*
 far-side pin source: external count clock, gate pin and comparator level.
 assumes the bench sets the levels and switches the clock on and off.
 */
`timescale 1ns/1ps
module pin_source_model (
	// control from bench
	input wire logic clk_on,
	input wire logic gate_lvl,
	input wire logic cmp_lvl,
	// pins
	output logic     ext_clk,
	output logic     gate_pin,
	output logic     cmp_pin
);
	// ***
	// pin drive
	// ***
	initial begin
		ext_clk = 1'b0;
		#7;
		forever #100 ext_clk = clk_on ? ~ext_clk : 1'b0;
	end
	assign gate_pin = gate_lvl;
	assign cmp_pin = cmp_lvl;
endmodule

//--- verification/sixteen_bit_timer_control_test.sv
/*
 self-checking bench for the timer control block.
 assumes design, package, header, pin model and checker compile first.
 */
`timescale 1ns/1ps
`include "timer_one_params.svh"
module sixteen_bit_timer_control_test;
	logic        aclk = 1'b0, aresetn = 1'b0, sb, clk_on = 1'b0, gate_lvl = 1'b0, cmp_lvl = 1'b0;
	logic [11:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
	logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
	logic [3:0]  s_axi_wstrb = 4'h0;
	logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
	logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, s_axi_awready, s_axi_wready;
	logic        s_axi_bvalid, s_axi_arready, s_axi_rvalid, low_power_osc_enable;
	logic        external_count_clock_pin, gate_input_pin, comparator_out;
	logic [1:0]  s_axi_bresp, s_axi_rresp;
	logic [15:0] count_value, v, w, e;
	int          error_cnt = 0, total_checks = 0, seed = 2972, n;
	always #12.5 aclk = ~aclk;
	sixteen_bit_timer_control i_sixteen_bit_timer_control (.aclk, .aresetn, .s_axi_awaddr,
		.s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
		.s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
		.s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .external_count_clock_pin,
		.gate_input_pin, .comparator_out, .low_power_osc_enable, .count_value);
	pin_source_model i_pin_source_model (.clk_on, .gate_lvl, .cmp_lvl,
		.ext_clk(external_count_clock_pin), .gate_pin(gate_input_pin), .cmp_pin(comparator_out));
	// ***
	// tasks
	// ***
	task automatic chk(input logic [31:0] g, input logic [31:0] x);
		total_checks++;
		if (g !== x) begin
			error_cnt++;
			$display("unexpected at %0t: got %h want %h", $time, g, x);
		end
	endtask
	task automatic tally_and_finish;
		$display("checks %0d mismatches %0d", total_checks, error_cnt);
		if (error_cnt == 0 && total_checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	task automatic hold(input logic rdy);
		for (n = 0; n < 50 && !rdy; n++) @(posedge aclk);
		if (n >= 50) begin
			error_cnt++;
			tally_and_finish();
		end
	endtask
	task automatic wr(input logic [11:0] a, input logic [15:0] d, input logic [3:0] s, input logic [1:0] r);
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= {16'h0, d};
		s_axi_wstrb <= s;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		for (n = 0; n < 50 && (s_axi_awvalid || s_axi_wvalid || n == 0); n++) begin
			@(posedge aclk);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
		end
		hold(n < 50);
		repeat (2) @(posedge aclk);
		s_axi_bready <= 1'b1;
		@(posedge aclk);
		for (n = 0; n < 50 && !s_axi_bvalid; n++) @(posedge aclk);
		hold(n < 50);
		chk(s_axi_bresp, r);
		s_axi_bready <= 1'b0;
	endtask
	task automatic rd(input logic [11:0] a, input logic [15:0] x, input logic [1:0] r);
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		@(posedge aclk);
		for (n = 0; n < 50 && !s_axi_arready; n++) @(posedge aclk);
		hold(n < 50);
		s_axi_arvalid <= 1'b0;
		@(posedge aclk);
		s_axi_rready <= 1'b1;
		@(posedge aclk);
		for (n = 0; n < 50 && !s_axi_rvalid; n++) @(posedge aclk);
		hold(n < 50);
		chk(s_axi_rdata, {16'h0, x});
		chk(s_axi_rresp, r);
		s_axi_rready <= 1'b0;
	endtask
	task automatic rate(input int c, input logic [15:0] x);
		v = count_value;
		repeat (c) @(posedge aclk);
		chk(16'(count_value - v), x);
	endtask
	// ***
	// scenarios
	// ***
	initial begin
		repeat (10) @(posedge aclk);
		aresetn <= 1'b1;
		rd(`CTRL_OFFSET, 16'h0000, `RESP_OKAY);
		rd(12'h00c, 16'h0000, `RESP_SLVERR);
		wr(12'h00c, 16'hffff, 4'hf, `RESP_SLVERR);
		wr(`COUNT_OFFSET, 16'hfffe, 4'h3, `RESP_OKAY);
		for (int p = 0; p < 4; p++) begin
			sb = $random(seed);
			wr(`CTRL_OFFSET, {10'h0, p[1:0], 1'b0, sb, 2'h1}, 4'h1, `RESP_OKAY);
			repeat (4) @(posedge aclk);
			rate(4 << p, 16'h4);
		end
		wr(`CTRL_OFFSET, 16'h0048, 4'h1, `RESP_OKAY);
		chk(low_power_osc_enable, 1'b1);
		rate(20, 16'h0);
		$display("prescale and stop done");
		wr(`COUNT_OFFSET, 16'h1234, 4'h3, `RESP_OKAY);
		e = 16'h1234;
		for (int s = 1; s < 4; s++) begin
			w = $random(seed);
			wr(`COUNT_OFFSET, w, s[3:0], `RESP_OKAY);
			e = {s[1] ? w[15:8] : e[15:8], s[0] ? w[7:0] : e[7:0]};
			rd(`COUNT_OFFSET, e, `RESP_OKAY);
		end
		wr(`CTRL_OFFSET, 16'h0031, 4'h1, `RESP_OKAY);
		for (int i = 0; i < 3; i++) begin
			w = $random(seed);
			wr(`COUNT_OFFSET, w, 4'h3, `RESP_OKAY);
			chk(count_value, w);
			repeat (4) @(posedge aclk);
			chk(count_value, w);
			repeat (8) @(posedge aclk);
			chk(count_value, 16'(w + 16'h1));
		end
		$display("count write done");
		for (int g = 0; g < 8; g++) begin
			wr(`GATE_SRC_OFFSET, {15'h0, g[2]}, 4'h1, `RESP_OKAY);
			gate_lvl <= g[1] ^ g[2];
			cmp_lvl <= g[1] ^ ~g[2];
			wr(`CTRL_OFFSET, {8'h0, g[0], 7'h41}, 4'h1, `RESP_OKAY);
			repeat (8) @(posedge aclk);
			rate(16, (g[1] == g[0]) ? 16'h10 : 16'h0);
		end
		$display("gate done");
		clk_on <= 1'b1;
		for (int b = 0; b < 4; b++) begin
			wr(`CTRL_OFFSET, {11'h0, b[1], 1'b0, b[0], 2'h3}, 4'h1, `RESP_OKAY);
			repeat (16) @(posedge aclk);
			rate(64, 16'h8 >> b[1]);
			if (!b[1]) begin
				for (n = 0; n < 20 && external_count_clock_pin; n++) @(posedge aclk);
				hold(n < 20);
				for (n = 0; n < 20 && !external_count_clock_pin; n++) @(posedge aclk);
				hold(n < 20);
				v = count_value;
				repeat (3) @(posedge aclk);
				chk(count_value, 16'(v + {15'h0, b[0]}));
				@(posedge aclk);
				chk(count_value, 16'(v + 16'h1));
			end
		end
		$display("external clock done");
		aresetn <= 1'b0;
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		chk(count_value, `COUNT_RESET);
		chk(low_power_osc_enable, 1'b0);
		rd(`CTRL_OFFSET, 16'h0000, `RESP_OKAY);
		$display("mid-run reset done");
		tally_and_finish();
	end
endmodule
